// ---- verilog/pmt_pkg.sv ----
package pmt_pkg;
    // ------------------------------------------------------------
    // Program store geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int WORD_W = 16;
    localparam int DEPTH = 4096;
    localparam int PAGE_W = 8;
    localparam int HI_W = ADDR_W - PAGE_W;
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [3:0] LAST_PAGE = 4'hf;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [7:0] DMEM_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic last_page;
        logic [7:0] ptr_lo;
        logic [7:0] ptr_hi;
        logic [7:0] dest;
    } pmt_tbl_req_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } pmt_dmem_wr_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [15:0] data;
    } pmt_prog_wr_t;

    typedef enum logic [0:0] {
        PMT_IDLE,
        PMT_SECOND
    } pmt_state_t;
endpackage

// ---- verilog/pmt_core.sv ----
`timescale 1ns/100ps
// Overview of operation
// - Program store of 4K words of 16 bits, fetched by program counter.
// - After reset the program counter is zero and fetching starts there.
// - Paged table read address joins low table pointer byte and low four bits of high pointer byte.
// - Low byte of the addressed word is written to the operand register.
// - High byte of the addressed word is loaded into the table-high latch.
// - Latch bits without stored program bits read as zero.
// - Table-high latch is read-only; only table reads and reset change it.
// - Every table read takes two instruction cycles.
// - Last-page variant ignores high pointer and uses page 0F00H.
// - Programming serial data pin is two-way, clocked by the programmer.
// - Debug data pin is two-way; debug clock is input only.
// - Low pointer selects a word within a 256-location page.
module pmt_core #(
    parameter int ADDR_W = pmt_pkg::ADDR_W,
    parameter int WORD_W = pmt_pkg::WORD_W,
    parameter int STORED_HI_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [11:0] pc_target,
    input wire pmt_pkg::pmt_tbl_req_t tbl_req,
    input wire pmt_pkg::pmt_prog_wr_t prog_wr,
    input wire logic prog_serial_data_in,
    input wire logic prog_serial_data_out_src,
    input wire logic prog_serial_drive,
    input wire logic prog_serial_clock,
    input wire logic debug_serial_data_in,
    input wire logic debug_serial_data_out_src,
    input wire logic debug_serial_drive,
    input wire logic debug_serial_clock,
    output logic [11:0] pc,
    output logic [15:0] instr,
    output logic busy,
    output pmt_pkg::pmt_dmem_wr_t dmem_wr,
    output logic [7:0] table_high_latch,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe_n,
    output logic prog_serial_data_sync,
    output logic prog_serial_clock_sync,
    output logic debug_serial_data_out,
    output logic debug_serial_data_oe_n,
    output logic debug_serial_data_sync,
    output logic debug_serial_clock_sync
);
    if (ADDR_W != pmt_pkg::ADDR_W || WORD_W != pmt_pkg::WORD_W || STORED_HI_W < 1
        || STORED_HI_W > 8)
    begin : g_bad_param
        $error("pmt_core: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Program store
    // ------------------------------------------------------------
    logic [15:0] mem_q [pmt_pkg::DEPTH];

    function automatic logic [11:0] tbl_addr(input pmt_pkg::pmt_tbl_req_t r);
        logic [3:0] page;
        page = r.last_page ? pmt_pkg::LAST_PAGE : r.ptr_hi[3:0];
        return {page, r.ptr_lo};
    endfunction

    always_ff @(posedge clk)
    begin
        if (clk_en && prog_wr.we)
            mem_q[prog_wr.addr] <= prog_wr.data;
    end

    // ------------------------------------------------------------
    // Fetch and table read sequencing
    // ------------------------------------------------------------
    pmt_pkg::pmt_state_t state_q, state_d;
    logic [11:0] pc_q, pc_d, taddr_q, taddr_d;
    logic [7:0] dest_q, dest_d, thl_q, thl_d;
    logic [15:0] instr_q, instr_d;
    pmt_pkg::pmt_dmem_wr_t dw_q, dw_d;
    logic [15:0] tword;
    logic [7:0] hi_mask;
    logic busy_q, busy_d;

    always_comb
    begin
        state_d = state_q;
        pc_d = pc_q;
        taddr_d = taddr_q;
        dest_d = dest_q;
        thl_d = thl_q;
        instr_d = instr_q;
        dw_d = '0;
        tword = mem_q[taddr_q];
        hi_mask = 8'hff >> (8 - STORED_HI_W);
        case (state_q)
            pmt_pkg::PMT_IDLE:
            begin
                if (tbl_req.start)
                begin
                    taddr_d = tbl_addr(tbl_req);
                    dest_d = tbl_req.dest;
                    state_d = pmt_pkg::PMT_SECOND;
                end
                else
                begin
                    if (pc_load)
                        pc_d = pc_target;
                    else if (pc_advance)
                        pc_d = pc_q + 12'h001;
                    instr_d = mem_q[pc_d];
                end
            end
            pmt_pkg::PMT_SECOND:
            begin
                dw_d.we = 1'b1;
                dw_d.addr = dest_q;
                dw_d.data = tword[7:0];
                thl_d = tword[15:8] & hi_mask;
                state_d = pmt_pkg::PMT_IDLE;
            end
            default:
                state_d = pmt_pkg::PMT_IDLE;
        endcase
        busy_d = (state_d == pmt_pkg::PMT_SECOND);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= pmt_pkg::PMT_IDLE;
            busy_q <= 1'b0;
            pc_q <= pmt_pkg::RESET_VECTOR;
            taddr_q <= pmt_pkg::RESET_VECTOR;
            dest_q <= pmt_pkg::DMEM_ZERO;
            thl_q <= pmt_pkg::BYTE_ZERO;
            instr_q <= pmt_pkg::WORD_ZERO;
            dw_q <= '0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            busy_q <= busy_d;
            pc_q <= pc_d;
            taddr_q <= taddr_d;
            dest_q <= dest_d;
            thl_q <= thl_d;
            instr_q <= instr_d;
            dw_q <= dw_d;
        end
    end

    // ------------------------------------------------------------
    // Serial pins: synchronisers and registered drive
    // ------------------------------------------------------------
    logic [2:0] sy_q [4];
    logic [2:0] sy_d [4];
    logic [3:0] sv_q, sv_d, raw;
    logic [1:0] po_q, po_d, pe_q, pe_d;

    assign raw = {debug_serial_clock, debug_serial_data_in, prog_serial_clock,
                  prog_serial_data_in};

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            sy_d[i] = {sy_q[i][1:0], raw[i]};
            sv_d[i] = (sy_q[i][1] == sy_q[i][2]) ? sy_q[i][2] : sv_q[i];
        end
        po_d = {debug_serial_data_out_src, prog_serial_data_out_src};
        pe_d = {~debug_serial_drive, ~prog_serial_drive};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 4; i++)
                sy_q[i] <= 3'h0;
            sv_q <= 4'h0;
            po_q <= 2'h0;
            pe_q <= 2'h3;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < 4; i++)
                sy_q[i] <= sy_d[i];
            sv_q <= sv_d;
            po_q <= po_d;
            pe_q <= pe_d;
        end
    end

    assign pc = pc_q;
    assign instr = instr_q;
    assign busy = busy_q;
    assign dmem_wr = dw_q;
    assign table_high_latch = thl_q;
    assign prog_serial_data_sync = sv_q[0];
    assign prog_serial_clock_sync = sv_q[1];
    assign debug_serial_data_sync = sv_q[2];
    assign debug_serial_clock_sync = sv_q[3];
    assign prog_serial_data_out = po_q[0];
    assign prog_serial_data_oe_n = pe_q[0];
    assign debug_serial_data_out = po_q[1];
    assign debug_serial_data_oe_n = pe_q[1];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence req_s;
        clk_en && !busy && tbl_req.start;
    endsequence

    two_cycle_a: assert property (@(posedge clk) disable iff (!resetn)
        req_s |=> busy) else $error("table read not two cycles");
    dmem_write_a: assert property (@(posedge clk) disable iff (!resetn)
        req_s ##1 clk_en |=> dmem_wr.we && dmem_wr.addr == $past(dest_q))
        else $error("operand register not written");
    latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(busy) |-> $stable(table_high_latch)) else $error("latch changed");
    latch_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        (table_high_latch & ~hi_mask) == 8'h00) else $error("unused latch bits set");
    last_page_a: assert property (@(posedge clk) disable iff (!resetn)
        (req_s and tbl_req.last_page) |=> taddr_q[11:8] == pmt_pkg::LAST_PAGE)
        else $error("last page not used");
    paged_addr_a: assert property (@(posedge clk) disable iff (!resetn)
        (req_s and !tbl_req.last_page) |=> taddr_q == {$past(tbl_req.ptr_hi[3:0]),
        $past(tbl_req.ptr_lo)}) else $error("table address wrong");
    no_write_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(busy) |-> !dmem_wr.we) else $error("stray data write");
    pc_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        busy |=> $stable(pc)) else $error("pc moved during table read");
endmodule // pmt_core

// ---- test/pmt_dmem_model.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// Data memory seen by the table read results
// ------------------------------------------------------------
module pmt_dmem_model (
    input wire logic clk,
    input wire pmt_pkg::pmt_dmem_wr_t dmem_wr
);
    logic [7:0] mem [256];
    always @(posedge clk)
    begin
        if (dmem_wr.we === 1'b1)
        begin
            mem[dmem_wr.addr] <= dmem_wr.data;
        end
    end
endmodule // pmt_dmem_model

// ---- test/tb_program_memory_table_read.sv ----
`timescale 1ns/100ps
module tb_program_memory_table_read;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic pc_advance = 1'b0;
    logic pc_load = 1'b0;
    logic [11:0] pc_target = 12'h000;
    pmt_pkg::pmt_tbl_req_t tbl_req = '0;
    pmt_pkg::pmt_prog_wr_t prog_wr = '0;
    logic clk_en = 1'b1;
    logic [7:0] ser = 8'h00;
    logic [11:0] pc;
    logic [15:0] instr;
    logic busy;
    pmt_pkg::pmt_dmem_wr_t dmem_wr;
    logic [7:0] table_high_latch;
    logic p_out, p_oen, p_dsync, p_csync, d_out, d_oen, d_dsync, d_csync;
    logic [5:0] pins;
    assign pins = {p_out, d_out, p_dsync, d_dsync, p_csync, d_csync};
    int n_errors = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    pmt_core #(.STORED_HI_W(6)) pmt_core_inst (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .pc_advance(pc_advance), .pc_load(pc_load), .pc_target(pc_target), .tbl_req(tbl_req),
        .prog_wr(prog_wr), .prog_serial_data_in(ser[0]), .prog_serial_data_out_src(ser[1]),
        .prog_serial_drive(ser[2]), .prog_serial_clock(ser[3]), .debug_serial_data_in(ser[4]),
        .debug_serial_data_out_src(ser[5]), .debug_serial_drive(ser[6]),
        .debug_serial_clock(ser[7]), .pc(pc), .instr(instr), .busy(busy), .dmem_wr(dmem_wr),
        .table_high_latch(table_high_latch), .prog_serial_data_out(p_out),
        .prog_serial_data_oe_n(p_oen), .prog_serial_data_sync(p_dsync),
        .prog_serial_clock_sync(p_csync), .debug_serial_data_out(d_out),
        .debug_serial_data_oe_n(d_oen), .debug_serial_data_sync(d_dsync),
        .debug_serial_clock_sync(d_csync));
    pmt_dmem_model pmt_dmem_model_inst (.clk(clk), .dmem_wr(dmem_wr));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic load(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk) prog_wr <= {1'b1, a, d};
        @(posedge clk) prog_wr.we <= 1'b0;
    endtask
    // Start held two cycles: the second edge falls in the busy cycle
    task automatic tread(input logic lp, input logic [7:0] hi, lo, dst, input logic [15:0] w);
        @(posedge clk) tbl_req <= {1'b1, lp, lo, hi, dst};
        @(posedge clk);
        #1 chk("busy", 16'h1, {15'h0, busy});
        @(posedge clk) tbl_req.start <= 1'b0;
        #1 chk("we", 16'h1, {15'h0, dmem_wr.we});
        chk("dmem addr", {8'h0, dst}, {8'h0, dmem_wr.addr});
        chk("dmem data", {8'h0, w[7:0]}, {8'h0, dmem_wr.data});
        chk("latch", {8'h0, w[15:8] & 8'h3f}, {8'h0, table_high_latch});
        @(posedge clk);
        #1 chk("no repeat", 16'h0, {15'h0, dmem_wr.we});
        chk("stored", {8'h0, w[7:0]}, {8'h0, pmt_dmem_model_inst.mem[dst]});
        $display("table read done");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1 chk("pc", 16'h0, {4'h0, pc});
        chk("latch reset", 16'h0, {8'h0, table_high_latch});
        chk("instr reset", 16'h0, instr);
        chk("busy reset", 16'h0, {15'h0, busy});
        chk("we reset", 16'h0, {15'h0, dmem_wr.we});
        chk("oe reset", 16'h3, {14'h0, p_oen, d_oen});
        $display("reset test done");
    endtask
    task automatic t_fetch();
        @(posedge clk) pc_load <= 1'b1;
        pc_target <= 12'h7ff;
        pc_advance <= 1'b1;
        @(posedge clk) pc_load <= 1'b0;
        #1 chk("pc load wins", 16'h07ff, {4'h0, pc});
        @(posedge clk) pc_advance <= 1'b0;
        #1 chk("pc adv", 16'h0800, {4'h0, pc});
        chk("instr", 16'hbeef, instr);
        $display("fetch test done");
    endtask
    task automatic t_serial();
        @(posedge clk) ser <= 8'h3c;
        repeat (6) @(posedge clk);
        #1 chk("oe a", 16'h1, {14'h0, p_oen, d_oen});
        chk("out sync a", 16'h16, {10'h0, pins});
        @(posedge clk) ser <= 8'hc3;
        repeat (6) @(posedge clk);
        #1 chk("oe b", 16'h2, {14'h0, p_oen, d_oen});
        chk("out sync b", 16'h29, {10'h0, pins});
        @(posedge clk) ser[0] <= 1'b0;
        @(posedge clk) ser[0] <= 1'b1;
        repeat (5)
        begin
            @(posedge clk);
            #1 chk("glitch", 16'h1, {15'h0, p_dsync});
        end
        $display("serial test done");
    endtask
    task automatic t_freeze();
        @(posedge clk) tbl_req <= {1'b1, 1'b0, 8'h24, 8'h03, 8'h43};
        @(posedge clk) tbl_req.start <= 1'b0;
        clk_en <= 1'b0;
        @(posedge clk) clk_en <= 1'b1;
        #1 chk("frozen busy", 16'h1, {15'h0, busy});
        chk("frozen we", 16'h0, {15'h0, dmem_wr.we});
        @(posedge clk);
        #1 chk("late we", 16'h1, {15'h0, dmem_wr.we});
        chk("late data", 16'h00a7, {8'h0, dmem_wr.data});
        chk("late latch", 16'h0005, {8'h0, table_high_latch});
        $display("freeze test done");
    endtask
    task automatic t_mid_reset();
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk);
        #1 chk("pc mid reset", 16'h0, {4'h0, pc});
        chk("latch mid reset", 16'h0, {8'h0, table_high_latch});
        @(posedge clk) resetn <= 1'b1;
        tread(1'b0, 8'h08, 8'h00, 8'h44, 16'hbeef);
        $display("mid reset test done");
    endtask
    initial
    begin
        #(20 * 3000);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        load(12'h800, 16'hbeef);
        load(12'h324, 16'hc5a7);
        load(12'h306, 16'h1111);
        load(12'hf06, 16'hff1a);
        load(12'hfff, 16'h7e01);
        t_fetch();
        tread(1'b0, 8'hf3, 8'h24, 8'h40, 16'hc5a7);
        tread(1'b1, 8'h03, 8'h06, 8'h41, 16'hff1a);
        tread(1'b1, 8'h00, 8'hff, 8'h42, 16'h7e01);
        t_freeze();
        t_serial();
        t_mid_reset();
        end_of_test();
    end
endmodule // tb_program_memory_table_read
